// >>> isa_cpu_model.sv
// Processor model that issues register reads and writes over APB.
// Assumes the bench calls xfer from one process at a time.
`timescale 1ns/100ps
module isa_cpu_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // A released bus shows inverted values so no stale word looks valid.
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask : xfer
endmodule : isa_cpu_model

// >>> isa_pkg.sv
// Constants for the interrupt status aggregator: register indices,
// field positions, reset values and the power request states.
// Assumes a 32-bit APB register port with one word per register index.
package isa_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // Register indices; the byte address is four times the index.
  localparam logic [9:0] IDX_SUMMARY  = 10'h000;
  localparam logic [9:0] IDX_DEVICE   = 10'h001;
  localparam logic [9:0] IDX_TOP_EN   = 10'h008;
  localparam logic [9:0] IDX_DEV_EN   = 10'h009;
  localparam logic [9:0] IDX_PWR      = 10'h00a;
  localparam logic [9:0] PORT1_BASE   = 10'h200;

  // Top summary fields.
  localparam int unsigned SUM_DEV  = 7;
  localparam int unsigned SUM_HOST = 6;
  localparam int unsigned SUM_CPU  = 5;
  localparam int unsigned SUM_FIFO = 4;
  localparam int unsigned SUM_PM   = 0;

  // Device status fields.
  localparam int unsigned DEV_VBUS  = 7;
  localparam int unsigned DEV_ENG   = 5;
  localparam int unsigned DEV_BULK  = 4;
  localparam int unsigned DEV_SETUP = 3;
  localparam int unsigned DEV_EP0   = 1;
  localparam int unsigned DEV_EPR   = 0;

  // Power control fields.
  localparam int unsigned PWR_SLEEP  = 0;
  localparam int unsigned PWR_ACTIVE = 1;
  localparam int unsigned PWR_STATE  = 7;

  localparam logic [7:0] SUM_RSVD_MASK = 8'h0e;
  localparam logic [7:0] DEV_RSVD_MASK = 8'h44;
  localparam logic [7:0] RESET_BYTE    = 8'h00;

  typedef enum logic [1:0] {
    PM_IDLE,
    PM_TO_SLEEP,
    PM_TO_ACTIVE
  } isa_pm_e;

endpackage : isa_pkg

// >>> isa_sync.sv
// Two flip-flop synchroniser for one level from a pin.
// Assumes the level may change at any time relative to pclk.
`timescale 1ns/100ps
module isa_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : isa_sync

// >>> isa_top.sv
// Interrupt status aggregator: top summary, device status, power request
// tracking and the active-low interrupt pin, behind an APB slave.
// Assumes group status blocks deliver already enable-gated pending levels.
`timescale 1ns/100ps

//////////////////////////////////////////////////////////////////////////////
// Contract
// [R01] Summary bits are read-only, follow their sources.
// [R02] Direct flags clear on writing one.
// [R03] Enabled set summary bit drives interrupt low.
// [R04] Interrupt releases once all enabled sources clear.
// [R05] Bits 7..4 reflect enabled group flags.
// [R06] Device and host summaries readable in sleep.
// [R07] Bit 0 sets when power request completes.
// [R08] Summary bits 3..1 are reserved.
// [R09] Device registers exist only on port 0.
// [R10] Port 1 registers sit at base 200h.
// [R11] Device bit 7 sets on bus-power change.
// [R12] Device status holds direct flags and summaries.
// [R13] Setup receipt sets flag and endpoint side effects.
// [R14] Reserved bits read zero, ignore writes.
module isa_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        vbus_pin,
  input  wire logic [1:0]  host_pending,
  input  wire logic [1:0]  cpu_pending,
  input  wire logic [1:0]  fifo_pending,
  input  wire logic        dev_engine_pending,
  input  wire logic        dev_bulk_pending,
  input  wire logic        dev_ep0_pending,
  input  wire logic        dev_epr_pending,
  input  wire logic        setup_stored,
  input  wire logic        setup_auto_address,
  input  wire logic        power_in_sleep,
  output logic             request_sleep,
  output logic             request_active,
  output logic             ep0_setup_update,
  output logic             interrupt_request_n
);

  logic [9:0]          idx;
  logic                port1;
  logic [9:0]          off;
  logic                hit;
  logic                wr_acc;
  logic                rd_setup;
  logic                vbus_s;
  logic                vbus_prev_r;
  logic                vbus_change;
  logic                setup_evt;
  logic                dev_vbus_r;
  logic                dev_setup_r;
  logic [1:0]          pm_done_r;
  logic                pm_evt;
  logic [7:0]          top_en_r [2];
  logic [7:0]          dev_en_r;
  logic [7:0]          dev_status;
  logic [7:0]          summary [2];
  logic [1:0]          port_active;
  logic                irq_n_r;
  logic [7:0]          rd_byte;
  isa_pkg::isa_pm_e    pm_state_r;

  //////////////////////////////////////////////////////////////////////////
  // APB decode. Zero wait states: read data is captured in the setup cycle.
  assign idx      = paddr[11:2];
  assign port1    = (idx >= isa_pkg::PORT1_BASE); // R10
  assign off      = port1 ? idx - isa_pkg::PORT1_BASE : idx; // R10
  assign wr_acc   = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign pready   = 1'b1;

  always_comb begin
    hit = 1'b0;
    unique case (off)
      isa_pkg::IDX_SUMMARY,
      isa_pkg::IDX_TOP_EN,
      isa_pkg::IDX_PWR:     hit = 1'b1;
      isa_pkg::IDX_DEVICE,
      isa_pkg::IDX_DEV_EN:  hit = !port1; // R09
      default:              hit = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus-power pin change detection.
  isa_sync u_vbus_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (vbus_pin),
    .sync_out (vbus_s)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vbus_prev_r <= 1'b0;
    end else begin
      vbus_prev_r <= vbus_s;
    end
  end

  assign vbus_change = vbus_s ^ vbus_prev_r; // R11

  //////////////////////////////////////////////////////////////////////////
  // Device direct flags. A new event in the clearing cycle wins.
  logic dev_w1c;
  assign dev_w1c   = wr_acc && hit && (off == isa_pkg::IDX_DEVICE);
  assign setup_evt = setup_stored && !setup_auto_address; // R13

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dev_vbus_r  <= 1'b0;
      dev_setup_r <= 1'b0;
    end else begin
      dev_vbus_r  <= (dev_vbus_r && !(dev_w1c && pwdata[isa_pkg::DEV_VBUS]))
                     || vbus_change; // R02 R11
      dev_setup_r <= (dev_setup_r && !(dev_w1c && pwdata[isa_pkg::DEV_SETUP]))
                     || setup_evt; // R02 R13
    end
  end

  // The endpoint block clears stall and sets NAK, toggle and protect on
  // this pulse, so both views change together with the flag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ep0_setup_update <= 1'b0;
    end else begin
      ep0_setup_update <= setup_evt; // R13
    end
  end

  always_comb begin
    dev_status                     = isa_pkg::RESET_BYTE;
    dev_status[isa_pkg::DEV_VBUS]  = dev_vbus_r;
    dev_status[isa_pkg::DEV_ENG]   = dev_engine_pending; // R12
    dev_status[isa_pkg::DEV_BULK]  = dev_bulk_pending;
    dev_status[isa_pkg::DEV_SETUP] = dev_setup_r;
    dev_status[isa_pkg::DEV_EP0]   = dev_ep0_pending;
    dev_status[isa_pkg::DEV_EPR]   = dev_epr_pending;
  end

  //////////////////////////////////////////////////////////////////////////
  // Power request tracking. Sleep wins if both requests are written.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pm_state_r <= isa_pkg::PM_IDLE;
    end else if (wr_acc && hit && off == isa_pkg::IDX_PWR &&
                 (pwdata[isa_pkg::PWR_SLEEP] ||
                  pwdata[isa_pkg::PWR_ACTIVE])) begin
      pm_state_r <= pwdata[isa_pkg::PWR_SLEEP] ? isa_pkg::PM_TO_SLEEP
                                               : isa_pkg::PM_TO_ACTIVE;
    end else if (pm_evt) begin
      pm_state_r <= isa_pkg::PM_IDLE;
    end
  end

  always_comb begin
    unique case (pm_state_r)
      isa_pkg::PM_TO_SLEEP:  pm_evt = power_in_sleep; // R07
      isa_pkg::PM_TO_ACTIVE: pm_evt = !power_in_sleep; // R07
      default:               pm_evt = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      request_sleep  <= 1'b0;
      request_active <= 1'b0;
    end else begin
      request_sleep  <= (pm_state_r == isa_pkg::PM_TO_SLEEP) && !pm_evt;
      request_active <= (pm_state_r == isa_pkg::PM_TO_ACTIVE) && !pm_evt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Device enable; per-port summary, enables and completion flag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dev_en_r <= isa_pkg::RESET_BYTE;
    end else if (wr_acc && hit && off == isa_pkg::IDX_DEV_EN) begin
      dev_en_r <= pwdata[7:0] & ~isa_pkg::DEV_RSVD_MASK; // R14
    end
  end

  for (genvar p = 0; p < 2; p++) begin : g_port
    logic sel_p;
    assign sel_p = wr_acc && hit && (port1 == (p == 1));
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        top_en_r[p]  <= isa_pkg::RESET_BYTE;
        pm_done_r[p] <= 1'b0;
      end else begin
        if (sel_p && off == isa_pkg::IDX_TOP_EN) begin
          top_en_r[p] <= pwdata[7:0] & ~isa_pkg::SUM_RSVD_MASK; // R08
        end
        pm_done_r[p] <= (pm_done_r[p] && !(sel_p &&
                         off == isa_pkg::IDX_SUMMARY &&
                         pwdata[isa_pkg::SUM_PM])) || pm_evt; // R02 R07
      end
    end
    // Summary bits are pure functions of their sources. R01
    always_comb begin
      summary[p]                   = isa_pkg::RESET_BYTE; // R08
      summary[p][isa_pkg::SUM_DEV] = (p == 0) && |(dev_status & dev_en_r);
      summary[p][isa_pkg::SUM_HOST] = host_pending[p]; // R05 R06
      summary[p][isa_pkg::SUM_CPU]  = cpu_pending[p]; // R05
      summary[p][isa_pkg::SUM_FIFO] = fifo_pending[p]; // R05
      summary[p][isa_pkg::SUM_PM]   = pm_done_r[p];
    end
    assign port_active[p] = |(summary[p] & top_en_r[p]);
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupt pin and read data.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_n_r <= 1'b1;
    end else begin
      irq_n_r <= !(|port_active); // R03 R04
    end
  end

  assign interrupt_request_n = irq_n_r;

  always_comb begin
    unique case (off)
      isa_pkg::IDX_SUMMARY: rd_byte = summary[port1];
      isa_pkg::IDX_DEVICE:  rd_byte = dev_status; // R12
      isa_pkg::IDX_TOP_EN:  rd_byte = top_en_r[port1];
      isa_pkg::IDX_DEV_EN:  rd_byte = dev_en_r;
      isa_pkg::IDX_PWR: begin
        rd_byte                     = isa_pkg::RESET_BYTE;
        rd_byte[isa_pkg::PWR_SLEEP]  = request_sleep;
        rd_byte[isa_pkg::PWR_ACTIVE] = request_active;
        rd_byte[isa_pkg::PWR_STATE]  = power_in_sleep;
      end
      default:              rd_byte = isa_pkg::RESET_BYTE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (rd_setup) begin
      prdata  <= {24'h000000, (hit && !pwrite) ? rd_byte : 8'h00};
      pslverr <= !hit; // R09
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Assertions.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_w1c_clear;
    dev_w1c && pwdata[isa_pkg::DEV_SETUP] && !setup_evt |=> !dev_setup_r;
  endproperty
  a_w1c_clear: assert property (p_w1c_clear) // R02
    else $error("setup flag not cleared by write of one");
  property p_irq_assert;
    |port_active |=> !interrupt_request_n;
  endproperty
  a_irq_assert: assert property (p_irq_assert) // R03
    else $error("interrupt pin not asserted");
  property p_irq_release;
    !interrupt_request_n |-> $past(port_active) != 2'b00;
  endproperty
  a_irq_release: assert property (p_irq_release) // R04
    else $error("interrupt pin low without enabled source");
  property p_group_follow;
    rd_setup && hit && !pwrite && off == isa_pkg::IDX_SUMMARY && !port1
      |=> prdata[isa_pkg::SUM_HOST] == $past(host_pending[0]) &&
          prdata[isa_pkg::SUM_FIFO] == $past(fifo_pending[0]);
  endproperty
  a_group_follow: assert property (p_group_follow) // R05
    else $error("summary read does not follow group pending");
  property p_pm_done;
    pm_state_r == isa_pkg::PM_TO_SLEEP && power_in_sleep
      |=> pm_done_r == 2'b11 && pm_state_r == isa_pkg::PM_IDLE;
  endproperty
  a_pm_done: assert property (p_pm_done) // R07
    else $error("power completion flag not set");
  property p_reserved;
    (summary[0] & isa_pkg::SUM_RSVD_MASK) == 8'h00 &&
    (dev_status & isa_pkg::DEV_RSVD_MASK) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) // R14
    else $error("reserved status bit set");
  property p_port1_device;
    rd_setup && port1 && off == isa_pkg::IDX_DEVICE |=> pslverr;
  endproperty
  a_port1_device: assert property (p_port1_device) // R09
    else $error("port 1 device register not refused");
  property p_vbus_flag;
    $changed(vbus_s) |=> dev_vbus_r;
  endproperty
  a_vbus_flag: assert property (p_vbus_flag) // R11
    else $error("bus power change not flagged");
  property p_setup;
    setup_stored |=> ep0_setup_update == !$past(setup_auto_address) &&
                     (dev_setup_r || $past(setup_auto_address));
  endproperty
  a_setup: assert property (p_setup) // R13
    else $error("setup receipt handling wrong");
  // Clearing both direct device flags drops the summary unless a group
  // summary still holds it up.
  property p_dev_summary;
    dev_w1c && pwdata[isa_pkg::DEV_VBUS] && pwdata[isa_pkg::DEV_SETUP] &&
    !vbus_change && !setup_evt |=> !summary[0][isa_pkg::SUM_DEV] ||
      dev_engine_pending || dev_bulk_pending || dev_ep0_pending ||
      dev_epr_pending;
  endproperty
  a_dev_summary: assert property (p_dev_summary) // R01
    else $error("device summary disagrees with its sources");
  property p_cov_irq;
    interrupt_request_n ##1 !interrupt_request_n ##[1:20] interrupt_request_n;
  endproperty
  c_cov_irq: cover property (p_cov_irq);
  property p_cov_pm;
    pm_state_r == isa_pkg::PM_TO_ACTIVE ##[1:20] pm_evt;
  endproperty
  c_cov_pm: cover property (p_cov_pm);
  property p_cov_race;
    dev_w1c && pwdata[isa_pkg::DEV_VBUS] && vbus_change;
  endproperty
  c_cov_race: cover property (p_cov_race);

endmodule : isa_top

// >>> tb.sv
// Self-checking bench for the interrupt status aggregator.
// Assumes the power unit and group sources are modelled here.
`timescale 1ns/100ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin \
  failures++; $display("mismatch %s exp %h got %h", n, e, a); end end
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        vbus_pin, setup_stored, setup_auto_address, power_in_sleep;
  logic [1:0]  host_p, cpu_p, fifo_p;
  logic [3:0]  dev_p;
  logic        request_sleep, request_active, ep0_setup_update, irq_n, err;
  logic        vb_f, su_f, pm0, pm1;
  logic [7:0]  ten;
  logic [2:0]  ep_seq;
  int          failures, cmp_count, cyc, seed, n, pwr_cnt;

  isa_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .vbus_pin(vbus_pin), .host_pending(host_p), .cpu_pending(cpu_p),
    .fifo_pending(fifo_p), .dev_engine_pending(dev_p[3]),
    .dev_bulk_pending(dev_p[2]), .dev_ep0_pending(dev_p[1]),
    .dev_epr_pending(dev_p[0]), .setup_stored(setup_stored),
    .setup_auto_address(setup_auto_address),
    .power_in_sleep(power_in_sleep), .request_sleep(request_sleep),
    .request_active(request_active), .ep0_setup_update(ep0_setup_update),
    .interrupt_request_n(irq_n));

  isa_cpu_model u_cpu (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // The power unit takes six cycles to reach the requested state.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_cnt        <= 0;
      power_in_sleep <= 1'b0;
    end else if ((request_sleep && !power_in_sleep) ||
                 (request_active && power_in_sleep)) begin
      pwr_cnt <= (pwr_cnt == 5) ? 0 : pwr_cnt + 1;
      if (pwr_cnt == 5) begin
        power_in_sleep <= request_sleep;
      end
    end
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] exp_dev();
    return {vb_f, 1'b0, dev_p[3:2], su_f, 1'b0, dev_p[1:0]};
  endfunction : exp_dev

  // Device status enable reads back as 8'hbb after a write of all ones.
  function automatic logic [7:0] exp_sum(input int p);
    return {p == 0 && |(exp_dev() & 8'hbb), host_p[p], cpu_p[p],
            fifo_p[p], 3'b000, p == 0 ? pm0 : pm1};
  endfunction : exp_sum

  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask : tick

  task automatic rd(input logic [11:0] a, input logic [7:0] e,
                    input logic ee);
    u_cpu.xfer(1'b0, a, 32'h0, q, err);
    `CHK("rdata", {24'h0, e}, q)
    `CHK("slverr", ee, err)
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    u_cpu.xfer(1'b1, a, {24'h0, d}, q, err);
  endtask : wr

  // Byte addresses are four times the index; port 1 starts at 12'h800.
  task automatic chk_all();
    tick(4);
    rd(12'h000, exp_sum(0), 1'b0);
    rd(12'h800, exp_sum(1), 1'b0);
    rd(12'h004, exp_dev(), 1'b0);
    `CHK("irq_n", !(|((exp_sum(0) | exp_sum(1)) & ten)), irq_n)
  endtask : chk_all

  task automatic complete_run();
    if (failures == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    {vbus_pin, setup_stored, setup_auto_address} = 3'h0;
    {host_p, cpu_p, fifo_p, dev_p} = 10'h0;
    {vb_f, su_f, pm0, pm1} = 4'h0;
    ten = 8'h00;
    seed = 32'h02c6;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    chk_all();
    rd(12'h804, 8'h00, 1'b1);
    rd(12'h3fc, 8'h00, 1'b1);
    wr(12'h024, 8'hff);
    rd(12'h024, 8'hbb, 1'b0);
    wr(12'h020, 8'hff);
    rd(12'h020, 8'hf1, 1'b0);
    wr(12'h820, 8'hff);
    ten = 8'hf1;
    for (int i = 0; i < 10; i++) begin
      @(posedge pclk);
      {host_p, cpu_p, fifo_p, dev_p} <= 10'($random(seed));
      chk_all();
    end
    @(posedge pclk);
    {host_p, cpu_p, fifo_p, dev_p} <= 10'h0;
    chk_all();
    host_p <= 2'b11;
    wr(12'h020, 8'h00);
    wr(12'h820, 8'h00);
    ten = 8'h00;
    chk_all();
    wr(12'h020, 8'hff);
    wr(12'h820, 8'hff);
    ten = 8'hf1;
    chk_all();
    host_p <= 2'b00;
    wr(12'h000, 8'hff);
    chk_all();
    vbus_pin <= 1'b1;
    vb_f = 1'b1;
    chk_all();
    wr(12'h004, 8'hff);
    vb_f = 1'b0;
    chk_all();
    @(posedge pclk) setup_stored <= 1'b1;
    @(posedge pclk) setup_stored <= 1'b0;
    #1;
    ep_seq[2] = ep0_setup_update;
    tick(1);
    ep_seq[1] = ep0_setup_update;
    tick(1);
    ep_seq[0] = ep0_setup_update;
    `CHK("ep0_update", 3'b100, ep_seq)
    su_f = 1'b1;
    chk_all();
    wr(12'h004, 8'h08);
    su_f = 1'b0;
    chk_all();
    @(posedge pclk);
    setup_stored       <= 1'b1;
    setup_auto_address <= 1'b1;
    @(posedge pclk) setup_stored <= 1'b0;
    chk_all();
    for (int t = 0; t < 2; t++) begin
      // First pass writes both request bits: sleep must win. Second pass writes the active request only.
      wr(12'h028, t == 0 ? 8'h03 : 8'h02);
      tick(1);
      `CHK("req", {t == 0, t != 0}, {request_sleep, request_active})
      n = 0;
      while (power_in_sleep !== (t == 0) && n < 50) begin
        tick(1);
        n++;
      end
      {pm0, pm1} = 2'b11;
      chk_all();
      rd(12'h028, t == 0 ? 8'h80 : 8'h00, 1'b0);
      wr(12'h000, 8'h01);
      wr(12'h800, 8'h01);
      {pm0, pm1} = 2'b00;
      chk_all();
    end
    complete_run();
  end
endmodule : tb
